// ==== common/obl_pkg.sv ====
// Purpose: constants, types and the register map of the option byte latch
// Assumes: 16-bit program address space, 32-bit AXI4-Lite data
// Notes:   field order of obl_opt_t fixes the bit layout of the option byte
//
// Operation
// - option byte sits at fixed nonvolatile location, copied into latches on each reset
// - protect bit 0 lets protected program memory be erased and written bytewise
// - protect bit 1 keeps reads, makes erase or program attempts to the protected span and the vectors fail outside bootloader mode
// - cleared protect bit only takes effect after power-on or external reset
// - single-chip mode always blocks writes to the first four program bytes
// - watchdog runs when disable bit is 0, stops when it is 1
// - watchdog, overtemp and overvoltage enables change only on power-on or external reset
// - oscillator monitor set and clock failing resets the core, switches to RC
// - halt-causes-reset bit set turns a stop instruction into a reset
// - overtemp reset disabled when its bit is 0, enabled when 1
// - overvoltage reset disabled when its bit is 0, enabled when 1
// - protected single-chip program memory is writable only in bootloader mode
package obl_pkg;

   // ==========================================================
   // widths and addresses
   localparam int          OBL_ADDR_W       = 16;
   localparam int          OBL_DATA_W       = 32;
   localparam int          OBL_SYNC_STAGES  = 3;
   localparam logic [15:0] OBL_NVM_OPT_ADDR = 16'h2000;
   localparam logic [15:0] OBL_PM_FIXED_LO  = 16'h2000;
   localparam logic [15:0] OBL_PM_FIXED_HI  = 16'h2003;
   localparam logic [15:0] OBL_PM_PROT_LO   = 16'h2004;
   localparam logic [15:0] OBL_PM_PROT_HI   = 16'h3eff;
   localparam logic [15:0] OBL_VEC_LO       = 16'h3ff0;
   localparam logic [15:0] OBL_VEC_HI       = 16'h3fff;

   // ==========================================================
   // register map
   localparam logic [15:0] OBL_REG_CTRL     = 16'h0000;
   localparam logic [15:0] OBL_REG_STATUS   = 16'h0004;
   localparam logic [15:0] OBL_REG_OPTION   = 16'h2000;
   localparam int          OBL_CTRL_RELOAD  = 0;
   localparam logic [1:0]  OBL_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  OBL_RESP_SLVERR  = 2'h2;

   // ==========================================================
   // types
   typedef struct packed {
      logic [1:0] rsvd;
      logic       program_memory_protect;
      logic       watchdog_disable;
      logic       oscillator_monitor_enable;
      logic       halt_causes_reset;
      logic       overtemp_reset_enable;
      logic       overvoltage_reset_enable;
   } obl_opt_t;

   typedef struct packed {
      logic single_chip;
      logic use_rc_osc;
      logic hard_load;
      logic loaded;
   } obl_status_t;

   localparam obl_opt_t OBL_OPT_RESET = 8'h00;

   typedef enum logic [2:0] {
      OBL_ST_REQ  = 3'b001,
      OBL_ST_WAIT = 3'b010,
      OBL_ST_RUN  = 3'b100
   } obl_state_t;

endpackage : obl_pkg

// ==== logic/obl_option_byte_latch.sv ====
// Purpose: loads the option byte from nonvolatile memory and drives device settings
// Assumes: aresetn is the power-on or external reset; soft_reset marks internal resets
// Notes:   nvm read port answers with nvm_rd_valid while nvm_rd_req is high
`timescale 1ns/1ns
module obl_option_byte_latch
   import obl_pkg::*;
#(
   parameter int ADDR_W = OBL_ADDR_W
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // nonvolatile memory read port
   output logic                   nvm_rd_req,
   output logic [15:0]            nvm_rd_addr,
   input  wire logic [7:0]        nvm_rd_data,
   input  wire logic              nvm_rd_valid,
   // reset controller and core
   input  wire logic              soft_reset,
   input  wire logic              single_chip_mode,
   input  wire logic              bootloader_mode,
   input  wire logic              halt_req,
   input  wire logic              osc_fail_async,
   input  wire logic              pm_wr_valid,
   input  wire logic [15:0]       pm_wr_addr,
   output logic                   pm_wr_grant,
   output logic                   pm_wr_deny,
   output logic                   halt_exec,
   output logic                   halt_reset,
   output logic                   osc_mon_reset,
   output logic                   use_rc_osc,
   output logic                   watchdog_enable,
   output logic                   overtemp_reset_enable,
   output logic                   overvoltage_reset_enable,
   output logic                   options_loaded
);

   // ==========================================================
   // helpers
   function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
      in_span = (a >= lo) && (a <= hi);
   endfunction : in_span

   // ==========================================================
   // loader state
   obl_state_t  state_q, state_d;
   obl_opt_t    opt_q, opt_d;
   obl_opt_t    raw_q, raw_d;
   logic        hard_q, hard_d;
   logic        loaded_q, loaded_d;
   logic        req_q, req_d;
   logic        wdog_en_q, wdog_en_d;
   logic        ot_en_q, ot_en_d;
   logic        ov_en_q, ov_en_d;
   logic        reload_q, reload_d;

   always_comb begin
      state_d   = state_q;
      opt_d     = opt_q;
      raw_d     = raw_q;
      hard_d    = hard_q;
      loaded_d  = loaded_q;
      req_d     = req_q;
      case (state_q)
         OBL_ST_REQ: begin
            req_d   = 1'b1;
            state_d = OBL_ST_WAIT;
         end
         OBL_ST_WAIT: begin
            if (nvm_rd_valid) begin
               req_d    = 1'b0;
               raw_d    = obl_opt_t'(nvm_rd_data);
               opt_d    = obl_opt_t'(nvm_rd_data);
               loaded_d = 1'b1;
               state_d  = OBL_ST_RUN;
               if (!hard_q) begin
                  opt_d.program_memory_protect = raw_d.program_memory_protect
                                               | opt_q.program_memory_protect;
                  opt_d.watchdog_disable         = opt_q.watchdog_disable;
                  opt_d.overtemp_reset_enable    = opt_q.overtemp_reset_enable;
                  opt_d.overvoltage_reset_enable = opt_q.overvoltage_reset_enable;
               end
            end
         end
         OBL_ST_RUN: begin
            if (soft_reset || reload_q) begin
               hard_d  = 1'b0;
               state_d = OBL_ST_REQ;
            end
         end
         default: state_d = OBL_ST_REQ;
      endcase
      wdog_en_d = ~opt_d.watchdog_disable;
      ot_en_d   = opt_d.overtemp_reset_enable;
      ov_en_d   = opt_d.overvoltage_reset_enable;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q   <= OBL_ST_REQ;
         opt_q     <= OBL_OPT_RESET;
         raw_q     <= OBL_OPT_RESET;
         hard_q    <= 1'b1;
         loaded_q  <= 1'b0;
         req_q     <= 1'b0;
         wdog_en_q <= 1'b1;
         ot_en_q   <= 1'b0;
         ov_en_q   <= 1'b0;
      end else if (ce) begin
         state_q   <= state_d;
         opt_q     <= opt_d;
         raw_q     <= raw_d;
         hard_q    <= hard_d;
         loaded_q  <= loaded_d;
         req_q     <= req_d;
         wdog_en_q <= wdog_en_d;
         ot_en_q   <= ot_en_d;
         ov_en_q   <= ov_en_d;
      end
   end

   // ==========================================================
   // register bus
   logic              awready_q, awready_d;
   logic              wready_q, wready_d;
   logic              bvalid_q, bvalid_d;
   logic [1:0]        bresp_q, bresp_d;
   logic              arready_q, arready_d;
   logic              rvalid_q, rvalid_d;
   logic [1:0]        rresp_q, rresp_d;
   logic [31:0]       rdata_q, rdata_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [31:0]       wdata_q, wdata_d;
   logic              wbyte0_q, wbyte0_d;
   logic              use_rc_q, use_rc_d;
   obl_status_t       status;

   assign status = '{single_chip: single_chip_mode, use_rc_osc: use_rc_q,
                     hard_load: hard_q, loaded: loaded_q};

   always_comb begin
      awready_d = awready_q;
      wready_d  = wready_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      arready_d = arready_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wbyte0_d  = wbyte0_q;
      reload_d  = 1'b0;
      if (s_axi_awvalid && awready_q) begin
         awaddr_d  = s_axi_awaddr;
         awready_d = 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
         wdata_d  = s_axi_wdata;
         wbyte0_d = s_axi_wstrb[0];
         wready_d = 1'b0;
      end
      if (!awready_q && !wready_q && !bvalid_q) begin
         bvalid_d = 1'b1;
         bresp_d  = OBL_RESP_OKAY;
         if (16'(awaddr_q) == OBL_REG_CTRL) begin
            reload_d = wbyte0_q & wdata_q[OBL_CTRL_RELOAD];
         end else if (16'(awaddr_q) == OBL_REG_STATUS
                      || 16'(awaddr_q) == OBL_REG_OPTION) begin
            bresp_d = OBL_RESP_OKAY;
         end else begin
            bresp_d = OBL_RESP_SLVERR;
         end
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d  = 1'b0;
         awready_d = 1'b1;
         wready_d  = 1'b1;
      end
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rresp_d   = OBL_RESP_OKAY;
         if (16'(s_axi_araddr) == OBL_REG_CTRL) begin
            rdata_d = '0;
         end else if (16'(s_axi_araddr) == OBL_REG_STATUS) begin
            rdata_d = 32'(status);
         end else if (16'(s_axi_araddr) == OBL_REG_OPTION) begin
            rdata_d = 32'(opt_q);
         end else begin
            rdata_d = '0;
            rresp_d = OBL_RESP_SLVERR;
         end
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= OBL_RESP_OKAY;
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= OBL_RESP_OKAY;
         rdata_q   <= '0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wbyte0_q  <= 1'b0;
         reload_q  <= 1'b0;
      end else if (ce) begin
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wbyte0_q  <= wbyte0_d;
         reload_q  <= reload_d;
      end
   end

   // ==========================================================
   // write checks, halt and oscillator monitor
   logic [OBL_SYNC_STAGES-1:0] osc_sync_q, osc_sync_d;
   logic                       osc_stable_q, osc_stable_d;
   logic                       osc_rst_q, osc_rst_d;
   logic                       grant_q, grant_d;
   logic                       deny_q, deny_d;
   logic                       hexec_q, hexec_d;
   logic                       hrst_q, hrst_d;
   logic                       prot_hit;

   assign prot_hit = in_span(pm_wr_addr, OBL_PM_PROT_LO, OBL_PM_PROT_HI)
                   | in_span(pm_wr_addr, OBL_VEC_LO, OBL_VEC_HI);

   always_comb begin
      osc_sync_d   = {osc_sync_q[OBL_SYNC_STAGES-2:0], osc_fail_async};
      osc_stable_d = osc_stable_q;
      osc_rst_d    = 1'b0;
      use_rc_d     = use_rc_q;
      grant_d      = 1'b0;
      deny_d       = 1'b0;
      hexec_d      = 1'b0;
      hrst_d       = 1'b0;
      if (osc_sync_q[1] == osc_sync_q[2]) begin
         osc_stable_d = osc_sync_q[2];
      end
      // clock failure resets and picks RC
      if (opt_q.oscillator_monitor_enable && osc_stable_d && !osc_stable_q) begin
         osc_rst_d = 1'b1;
         use_rc_d  = 1'b1;
      end
      if (pm_wr_valid) begin
         if (!loaded_q) begin
            deny_d = 1'b1;
         end else if (single_chip_mode
                      && in_span(pm_wr_addr, OBL_PM_FIXED_LO, OBL_PM_FIXED_HI)) begin
            deny_d = 1'b1;
         end else if (opt_q.program_memory_protect && prot_hit && !bootloader_mode) begin
            deny_d = 1'b1;
         end else begin
            grant_d = 1'b1;
         end
      end
      if (halt_req) begin
         hrst_d  = opt_q.halt_causes_reset;
         hexec_d = ~opt_q.halt_causes_reset;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_sync_q   <= '0;
         osc_stable_q <= 1'b0;
         osc_rst_q    <= 1'b0;
         use_rc_q     <= 1'b0;
         grant_q      <= 1'b0;
         deny_q       <= 1'b0;
         hexec_q      <= 1'b0;
         hrst_q       <= 1'b0;
      end else if (ce) begin
         osc_sync_q   <= osc_sync_d;
         osc_stable_q <= osc_stable_d;
         osc_rst_q    <= osc_rst_d;
         use_rc_q     <= use_rc_d;
         grant_q      <= grant_d;
         deny_q       <= deny_d;
         hexec_q      <= hexec_d;
         hrst_q       <= hrst_d;
      end
   end

   // ==========================================================
   // outputs
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign nvm_rd_req    = req_q;
   assign nvm_rd_addr   = OBL_NVM_OPT_ADDR;
   assign pm_wr_grant   = grant_q;
   assign pm_wr_deny    = deny_q;
   assign halt_exec     = hexec_q;
   assign halt_reset    = hrst_q;
   assign osc_mon_reset = osc_rst_q;
   assign use_rc_osc    = use_rc_q;
   assign watchdog_enable          = wdog_en_q;
   assign overtemp_reset_enable    = ot_en_q;
   assign overvoltage_reset_enable = ov_en_q;
   assign options_loaded           = loaded_q;

endmodule : obl_option_byte_latch

// ==== dv/obl_nvm_model.sv ====
// Purpose: nonvolatile read port that serves the option byte
// Assumes: one request at a time, answered dly+1 cycles after it rises
// Notes:   data lines show the inverted byte outside the answer cycle
`timescale 1ns/1ns
module obl_nvm_model
   import obl_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        nvm_rd_req,
   input  wire logic [15:0] nvm_rd_addr,
   input  wire logic [7:0]  opt_byte,
   input  wire logic [3:0]  dly,
   output logic [7:0]       nvm_rd_data,
   output logic             nvm_rd_valid
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       valid_d;

   assign nvm_rd_data = (nvm_rd_valid && nvm_rd_addr == OBL_NVM_OPT_ADDR) ? opt_byte : ~opt_byte;

   always_comb begin
      cnt_d   = cnt_q + 4'h1;
      valid_d = 1'b0;
      if (!nvm_rd_req || nvm_rd_valid) begin
         cnt_d = 4'h0;
      end else if (cnt_q >= dly) begin
         valid_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      cnt_q        <= cnt_d;
      nvm_rd_valid <= valid_d;
   end
endmodule : obl_nvm_model

// ==== dv/obl_option_byte_latch_sva.sv ====
// Purpose: port checks of the option byte latch
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ns
module obl_checker
   import obl_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic        nvm_rd_req,
   input wire logic        nvm_rd_valid,
   input wire logic        single_chip_mode,
   input wire logic        halt_req,
   input wire logic        pm_wr_valid,
   input wire logic [15:0] pm_wr_addr,
   input wire logic        pm_wr_grant,
   input wire logic        pm_wr_deny,
   input wire logic        halt_exec,
   input wire logic        halt_reset,
   input wire logic        osc_mon_reset,
   input wire logic        use_rc_osc,
   input wire logic        watchdog_enable,
   input wire logic        overtemp_reset_enable,
   input wire logic        overvoltage_reset_enable,
   input wire logic        options_loaded
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_byte_taken; ce && nvm_rd_req && nvm_rd_valid; endsequence
   sequence s_load_done; !nvm_rd_req && options_loaded; endsequence

   property p_load_start; $rose(aresetn) |-> ##[1:4] nvm_rd_req; endproperty
   property p_load_end; s_byte_taken |=> s_load_done; endproperty
   property p_one_answer; ce && pm_wr_valid |=> pm_wr_grant != pm_wr_deny; endproperty
   property p_deny_unloaded; ce && pm_wr_valid && !options_loaded |=> pm_wr_deny; endproperty
   property p_fixed_bytes;
      ce && pm_wr_valid && single_chip_mode && pm_wr_addr[15:2] == OBL_PM_FIXED_LO[15:2]
      |=> pm_wr_deny;
   endproperty
   property p_halt; ce && halt_req |=> halt_exec != halt_reset; endproperty
   property p_steady;
      options_loaded && $past(options_loaded) |-> $stable({watchdog_enable,
         overtemp_reset_enable, overvoltage_reset_enable});
   endproperty
   property p_rc_sticky; osc_mon_reset |-> use_rc_osc ##1 use_rc_osc; endproperty

   a_load_start: assert property (p_load_start)
      else $error("option fetch did not start");
   a_load_end: assert property (p_load_end)
      else $error("option fetch did not complete");
   a_one_answer: assert property (p_one_answer)
      else $error("write attempt not answered once");
   a_deny_unloaded: assert property (p_deny_unloaded)
      else $error("write granted before options loaded");
   a_fixed_bytes: assert property (p_fixed_bytes)
      else $error("write to fixed bytes granted");
   a_halt: assert property (p_halt)
      else $error("halt not answered once");
   a_steady: assert property (p_steady)
      else $error("enable changed between resets");
   a_rc_sticky: assert property (p_rc_sticky)
      else $error("rc oscillator select not held");
endmodule : obl_checker

// ==== dv/obl_option_byte_latch_test.sv ====
// Purpose: self-checking bench for the option byte latch
// Assumes: option byte served by obl_nvm_model
// Notes:   table rows cover the write gate, hand tests the reloads
`timescale 1ns/1ns
module obl_option_byte_latch_test
   import obl_pkg::*;
;
   typedef struct packed {
      logic [7:0]  opt;
      logic        sc;
      logic        boot;
      logic [15:0] addr;
      logic        grant;
   } obl_row_t;

   logic        aclk, aresetn, ce, soft_reset, single_chip_mode, bootloader_mode, halt_req;
   logic        osc_fail_async, pm_wr_valid, nvm_rd_valid, nvm_rd_req, pm_wr_grant, pm_wr_deny;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        halt_exec, halt_reset, osc_mon_reset, use_rc_osc, watchdog_enable;
   logic        overtemp_reset_enable, overvoltage_reset_enable, options_loaded;
   logic [15:0] s_axi_awaddr, s_axi_araddr, pm_wr_addr, nvm_rd_addr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb, nvm_dly;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [7:0]  nvm_rd_data, nvm_byte, cur;
   int          failures, n_compared, n;
   obl_row_t    rows [9];

   initial aclk = 1'b0;
   always #5 aclk = ~aclk;

   obl_option_byte_latch u_dut (
      .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_data, .nvm_rd_valid,
      .soft_reset, .single_chip_mode, .bootloader_mode, .halt_req, .osc_fail_async,
      .pm_wr_valid, .pm_wr_addr, .pm_wr_grant, .pm_wr_deny, .halt_exec, .halt_reset,
      .osc_mon_reset, .use_rc_osc, .watchdog_enable, .overtemp_reset_enable,
      .overvoltage_reset_enable, .options_loaded);

   obl_nvm_model u_nvm (.aclk, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_data, .nvm_rd_valid,
      .opt_byte(nvm_byte), .dly(nvm_dly));

   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
      if (what == "wait") print_verdict();
   endtask : chk

   task automatic wait_load;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!(nvm_rd_req === 1'b1 && nvm_rd_valid === 1'b1) && n < 100);
      if (n >= 100) chk("wait", 1, 0);
      @(posedge aclk);
      #1;
   endtask : wait_load

   task automatic pm_try(input logic sc, input logic boot, input logic [15:0] a, input logic g);
      @(posedge aclk);
      single_chip_mode <= sc;
      bootloader_mode  <= boot;
      pm_wr_addr       <= a;
      pm_wr_valid      <= 1'b1;
      @(posedge aclk);
      pm_wr_valid <= 1'b0;
      #1;
      chk("write gate", {30'h0, !g, g}, {30'h0, pm_wr_deny, pm_wr_grant});
   endtask : pm_try

   task automatic check_opts;
      chk("enables", {29'h0, !cur[4], cur[1:0]}, {29'h0, watchdog_enable,
         overtemp_reset_enable, overvoltage_reset_enable});
      @(posedge aclk);
      halt_req <= 1'b1;
      @(posedge aclk);
      halt_req <= 1'b0;
      #1;
      chk("halt", {30'h0, !cur[2], cur[2]}, {30'h0, halt_exec, halt_reset});
   endtask : check_opts

   task automatic hard_load(input logic [7:0] b);
      @(posedge aclk);
      nvm_byte <= b;
      aresetn  <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wait_load();
      cur = b;
   endtask : hard_load

   task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      if (n >= 50) chk("wait", 1, 0);
   endtask : axi_wr

   task automatic axi_rd(input logic [15:0] a);
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      rd   = s_axi_rdata;
      resp = s_axi_rresp;
      if (n >= 50) chk("wait", 1, 0);
   endtask : axi_rd

   initial begin
      rows = '{'{8'h00, 1'b1, 1'b0, 16'h2000, 1'b0}, '{8'h00, 1'b1, 1'b0, 16'h2003, 1'b0},
               '{8'h00, 1'b0, 1'b0, 16'h2002, 1'b1}, '{8'h00, 1'b1, 1'b0, 16'h2004, 1'b1},
               '{8'h3f, 1'b1, 1'b0, 16'h2004, 1'b0}, '{8'h3f, 1'b0, 1'b0, 16'h3eff, 1'b0},
               '{8'h3f, 1'b1, 1'b0, 16'h3ff0, 1'b0}, '{8'h3f, 1'b1, 1'b1, 16'h3eff, 1'b1},
               '{8'h3f, 1'b1, 1'b0, 16'h3f00, 1'b1}};
      {aresetn, soft_reset, bootloader_mode, halt_req, osc_fail_async, pm_wr_valid} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, pm_wr_addr, s_axi_wdata} = '0;
      {ce, single_chip_mode, s_axi_wstrb, nvm_dly, nvm_byte, cur} = {2'h3, 4'hf, 4'h6, 16'h0};
      failures   = 0;
      n_compared = 0;
      repeat (8) @(posedge aclk);
      #1;
      chk("loaded in reset", 0, options_loaded);
      @(posedge aclk);
      aresetn <= 1'b1;
      pm_try(1'b1, 1'b0, 16'h2004, 1'b0);
      wait_load();
      check_opts();
      nvm_dly <= 4'h1;
      for (int i = 0; i < 9; i++) begin
         if (rows[i].opt !== cur) begin
            hard_load(rows[i].opt);
            check_opts();
         end
         pm_try(rows[i].sc, rows[i].boot, rows[i].addr, rows[i].grant);
      end
      axi_rd(OBL_REG_OPTION);
      chk("option byte", 32'h3f, rd);
      axi_rd(16'h0100);
      chk("unmapped read", {30'h0, OBL_RESP_SLVERR}, {rd[29:0], resp});
      axi_wr(16'h0100, 32'h1);
      chk("unmapped write", OBL_RESP_SLVERR, resp);
      osc_fail_async <= 1'b1;
      n = 0;
      while (osc_mon_reset !== 1'b1 && n < 20) begin
         @(posedge aclk);
         n++;
      end
      #1;
      chk("clock monitor", 32'h1, {31'h0, use_rc_osc && n < 20});
      axi_rd(OBL_REG_STATUS);
      chk("status", 32'hf, rd);
      osc_fail_async <= 1'b0;
      nvm_byte       <= 8'h00;
      soft_reset     <= 1'b1;
      @(posedge aclk);
      soft_reset <= 1'b0;
      wait_load();
      axi_rd(OBL_REG_OPTION);
      chk("soft option byte", 32'h33, rd);
      axi_rd(OBL_REG_STATUS);
      chk("soft status", 32'hd, rd);
      pm_try(1'b1, 1'b0, 16'h2004, 1'b0);
      nvm_byte <= 8'h04;
      axi_wr(OBL_REG_CTRL, 32'h1);
      chk("reload resp", OBL_RESP_OKAY, resp);
      wait_load();
      axi_rd(OBL_REG_OPTION);
      chk("ctrl option byte", 32'h37, rd);
      hard_load(8'h00);
      check_opts();
      pm_try(1'b1, 1'b0, 16'h2004, 1'b1);
      osc_fail_async <= 1'b1;
      n = 0;
      repeat (12) begin
         @(posedge aclk);
         if (osc_mon_reset !== 1'b0) n++;
      end
      chk("monitor off", 0, n);
      ce       <= 1'b0;
      halt_req <= 1'b1;
      repeat (3) @(posedge aclk);
      halt_req <= 1'b0;
      ce       <= 1'b1;
      #1;
      chk("frozen halt", 0, {halt_exec, halt_reset});
      print_verdict();
   end
endmodule : obl_option_byte_latch_test

bind obl_option_byte_latch obl_checker u_chk (.aclk, .aresetn, .ce, .nvm_rd_req, .nvm_rd_valid,
   .single_chip_mode, .halt_req, .pm_wr_valid, .pm_wr_addr, .pm_wr_grant, .pm_wr_deny,
   .halt_exec, .halt_reset, .osc_mon_reset, .use_rc_osc, .watchdog_enable,
   .overtemp_reset_enable, .overvoltage_reset_enable, .options_loaded);
